// ===== rtl/orient_comp_pkg.sv
// Constants for the orientation compensation block: configuration memory
// layout, factory defaults, APB register map and float field positions.
// Assumes a single clock domain and 32-bit APB data.
package orient_comp_pkg;

  // ==========================================================================
  // Configuration memory layout (byte offsets)
  // ==========================================================================
  localparam int CFG_USED_BYTES = 136;
  localparam logic [7:0] ACCEL_OFFSET_VECTOR = 8'h00;
  localparam logic [7:0] ACCEL_TARE_MATRIX = 8'h0c;
  localparam logic [7:0] FIELD_HARD_IRON_OFFSET = 8'h30;
  localparam logic [7:0] FIELD_SOFT_IRON_MATRIX = 8'h3c;
  localparam logic [7:0] FIELD_TARE_MATRIX = 8'h60;
  localparam logic [7:0] SAMPLE_RATE_OFS = 8'h84;
  localparam logic [7:0] DECIMATION_RATIO_OFS = 8'h85;
  localparam logic [7:0] ACCEL_CONVERTER_OFS = 8'h86;
  localparam logic [7:0] FIELD_CONVERTER_OFS = 8'h87;
  localparam logic [7:0] RESERVED_BASE = 8'h88;
  localparam int RESERVED_BYTES = 120;
  localparam logic [7:0] COEF_BYTES = 8'h04;
  localparam logic [7:0] ROW_BYTES = 8'h0c;

  // ==========================================================================
  // Factory defaults
  // ==========================================================================
  localparam logic [7:0] ONE_BYTE0 = 8'h3f;
  localparam logic [7:0] ONE_BYTE1 = 8'h80;
  localparam logic [7:0] DIAG_STEP = 8'h10;
  localparam logic [7:0] SAMPLE_RATE_RST = 8'h00;
  localparam logic [7:0] DECIMATION_RATIO_RST = 8'h01;
  localparam logic [7:0] ACCEL_CONVERTER_RST = 8'h03;
  localparam logic [7:0] FIELD_CONVERTER_RST = 8'h20;

  // ==========================================================================
  // APB register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] REG_MEM_ADDR = 8'h00;
  localparam logic [7:0] REG_MEM_DATA = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_IN_ACCEL = 8'h10;
  localparam logic [7:0] REG_IN_FIELD = 8'h1c;
  localparam logic [7:0] REG_OUT_ACCEL = 8'h28;
  localparam logic [7:0] REG_OUT_FIELD = 8'h34;
  localparam logic [7:0] REG_LAST = 8'h3c;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // ==========================================================================
  // Single-precision float fields and engine state encoding
  // ==========================================================================
  localparam int FP_W = 32;
  localparam int FP_MAN = 23;
  localparam logic signed [9:0] FP_BIAS = 10'sd127;
  localparam logic signed [9:0] FP_EXP_MAX = 10'sd255;
  localparam logic [31:0] FP_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_A_SUB = 3'b001,
    ST_A_MUL = 3'b011,
    ST_H_SUB = 3'b010,
    ST_H_SOFT = 3'b110,
    ST_H_TARE = 3'b111
  } comp_state_t;

  // Factory image of a used configuration byte
  function automatic logic [7:0] default_byte(input int a);
    int rel;
    rel = -1;
    if (a >= ACCEL_TARE_MATRIX && a < FIELD_HARD_IRON_OFFSET) rel = a - ACCEL_TARE_MATRIX;
    if (a >= FIELD_SOFT_IRON_MATRIX && a < FIELD_TARE_MATRIX) rel = a - FIELD_SOFT_IRON_MATRIX;
    if (a >= FIELD_TARE_MATRIX && a < SAMPLE_RATE_OFS) rel = a - FIELD_TARE_MATRIX;
    if (a == SAMPLE_RATE_OFS) return SAMPLE_RATE_RST;
    if (a == DECIMATION_RATIO_OFS) return DECIMATION_RATIO_RST;
    if (a == ACCEL_CONVERTER_OFS) return ACCEL_CONVERTER_RST;
    if (a == FIELD_CONVERTER_OFS) return FIELD_CONVERTER_RST;
    if (rel >= 0 && (rel % DIAG_STEP) == 0) return ONE_BYTE0;
    if (rel >= 0 && (rel % DIAG_STEP) == 1) return ONE_BYTE1;
    return 8'h00;
  endfunction : default_byte

endpackage : orient_comp_pkg

// ===== rtl/orient_comp.sv
// Orientation compensation: configuration byte store behind an APB slave and
// a sequential float engine computing the compensated vectors.
// Assumes one clock (pclk), asynchronous active-low reset, an APB master.
`timescale 1ns/10ps
`default_nettype none

module orient_comp
  import orient_comp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic log_mode_we,
  input wire logic [7:0] log_sample_rate,
  input wire logic [7:0] log_decimation_ratio,
  output logic [7:0] sample_rate_byte,
  output logic [7:0] decimation_ratio_byte,
  output logic [7:0] accel_converter_setup,
  output logic [7:0] field_converter_setup
);

  // ==========================================================================
  // Float arithmetic (denormals flush to zero, round to nearest even)
  // ==========================================================================
  function automatic logic [31:0] fp_mul(input logic [31:0] a, input logic [31:0] b);
    logic s;
    logic [47:0] p;
    logic signed [9:0] e;
    logic up;
    logic [24:0] r;
    s = a[FP_W-1] ^ b[FP_W-1];
    p = {1'b1, a[FP_MAN-1:0]} * {1'b1, b[FP_MAN-1:0]};
    e = $signed({2'b00, a[30:FP_MAN]}) + $signed({2'b00, b[30:FP_MAN]}) - FP_BIAS;
    if (a[30:FP_MAN] == 8'h00 || b[30:FP_MAN] == 8'h00) return {s, 31'h0};
    if (a[30:FP_MAN] == 8'hff || b[30:FP_MAN] == 8'hff) return {s, 8'hff, 23'h0};
    if (p[47]) e = e + 10'sd1;
    else p = p << 1;
    up = p[23] & ((|p[22:0]) | p[24]);
    r = {1'b0, p[47:24]} + {24'h0, up};
    if (r[24]) begin
      r = r >> 1;
      e = e + 10'sd1;
    end
    if (e >= FP_EXP_MAX) return {s, 8'hff, 23'h0};
    if (e <= 10'sd0) return {s, 31'h0};
    return {s, e[7:0], r[FP_MAN-1:0]};
  endfunction : fp_mul

  function automatic logic [31:0] fp_add(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] big;
    logic [31:0] sml;
    logic [26:0] mb;
    logic [26:0] ms;
    logic [27:0] sum;
    logic [7:0] d;
    logic signed [9:0] e;
    logic up;
    logic [24:0] r;
    if (a[30:0] < b[30:0]) begin
      big = b;
      sml = a;
    end else begin
      big = a;
      sml = b;
    end
    mb = {1'b1, big[FP_MAN-1:0], 3'b000};
    ms = {1'b1, sml[FP_MAN-1:0], 3'b000};
    d = big[30:FP_MAN] - sml[30:FP_MAN];
    e = $signed({2'b00, big[30:FP_MAN]});
    if (big[30:FP_MAN] == 8'h00) return FP_ZERO;
    if (sml[30:FP_MAN] == 8'h00) return big;
    if (big[30:FP_MAN] == 8'hff) return big;
    // Shifted-out bits collapse into a sticky bit for correct rounding
    if (d > 8'd26) ms = 27'd1;
    else ms = (ms >> d) | {26'h0, |(ms & ((27'd1 << d) - 27'd1))};
    if (big[FP_W-1] == sml[FP_W-1]) sum = {1'b0, mb} + {1'b0, ms};
    else sum = {1'b0, mb} - {1'b0, ms};
    if (sum == 28'h0) return FP_ZERO;
    if (sum[27]) begin
      sum = {1'b0, sum[27:2], sum[1] | sum[0]};
      e = e + 10'sd1;
    end
    for (int k = 0; k < 26; k++) begin
      if (!sum[26]) begin
        sum = sum << 1;
        e = e - 10'sd1;
      end
    end
    up = sum[2] & ((|sum[1:0]) | sum[3]);
    r = {1'b0, sum[26:3]} + {24'h0, up};
    if (r[24]) begin
      r = r >> 1;
      e = e + 10'sd1;
    end
    if (e >= FP_EXP_MAX) return {big[FP_W-1], 8'hff, 23'h0};
    if (e <= 10'sd0) return FP_ZERO;
    return {big[FP_W-1], e[7:0], r[FP_MAN-1:0]};
  endfunction : fp_add

  // ==========================================================================
  // State
  // ==========================================================================
  logic [7:0] cfg_q [CFG_USED_BYTES];
  logic [7:0] mem_addr_q;
  logic [31:0] in_a_q [3];
  logic [31:0] in_h_q [3];
  logic [31:0] out_a_q [3];
  logic [31:0] out_h_q [3];
  logic [31:0] diff_q [3];
  logic [31:0] soft_q [3];
  logic [31:0] acc_q;
  logic [1:0] row_q;
  logic [1:0] col_q;
  logic done_q;
  comp_state_t state_q;
  comp_state_t state_d;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  wire logic [7:0] reg_ofs = paddr[7:0];
  wire logic hi_zero = (paddr[ADDR_W-1:8] == '0);
  wire logic busy = (state_q != ST_IDLE);
  wire logic setup_ok = psel & penable;
  // Writes wait while a measurement runs so it sees one coherent set
  wire logic stall = busy & pwrite;
  wire logic mapped = hi_zero && reg_ofs <= REG_LAST && reg_ofs[1:0] == 2'b00;
  wire logic acc_done = setup_ok & ~stall;
  wire logic wr_en = acc_done & pwrite & mapped;
  wire logic sel_mem = (reg_ofs == REG_MEM_DATA);
  wire logic sel_ctrl = (reg_ofs == REG_CTRL);
  wire logic sel_in_a = (reg_ofs >= REG_IN_ACCEL) && (reg_ofs < REG_IN_FIELD);
  wire logic sel_in_h = (reg_ofs >= REG_IN_FIELD) && (reg_ofs < REG_OUT_ACCEL);
  wire logic [1:0] vec_idx = 2'((reg_ofs - (sel_in_h ? REG_IN_FIELD : REG_IN_ACCEL)) >> 2);
  wire logic full_word = (pstrb == 4'hf);
  // Reserved bytes read as zero and ignore writes
  wire logic mem_in_range = (mem_addr_q < RESERVED_BASE);
  wire logic mem_wr = wr_en & sel_mem & pstrb[0] & mem_in_range;
  wire logic start = wr_en & sel_ctrl & pwdata[CTRL_START_BIT] & ~busy;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (reg_ofs == REG_MEM_ADDR) rd_mux = {24'h0, mem_addr_q};
    else if (sel_mem) rd_mux = {24'h0, mem_in_range ? cfg_q[mem_addr_q] : 8'h00};
    else if (reg_ofs == REG_STATUS) rd_mux = {30'h0, done_q, busy};
    else if (sel_in_a) rd_mux = in_a_q[vec_idx];
    else if (sel_in_h) rd_mux = in_h_q[vec_idx];
    else if (reg_ofs >= REG_OUT_FIELD && reg_ofs <= REG_LAST)
      rd_mux = out_h_q[2'((reg_ofs - REG_OUT_FIELD) >> 2)];
    else if (reg_ofs >= REG_OUT_ACCEL && reg_ofs < REG_OUT_FIELD)
      rd_mux = out_a_q[2'((reg_ofs - REG_OUT_ACCEL) >> 2)];
  end

  assign pready = ~(psel & penable & stall);
  assign pslverr = setup_ok & ~stall & ~mapped;
  assign prdata = (setup_ok & ~pwrite & mapped) ? rd_mux : 32'h0;

  // ==========================================================================
  // Coefficient fetch straight from the byte store
  // ==========================================================================
  wire logic is_sub = (state_q == ST_A_SUB) || (state_q == ST_H_SUB);
  logic [7:0] coef_base;
  always_comb begin
    case (state_q)
      ST_A_SUB: coef_base = ACCEL_OFFSET_VECTOR;
      ST_A_MUL: coef_base = ACCEL_TARE_MATRIX;
      ST_H_SUB: coef_base = FIELD_HARD_IRON_OFFSET;
      ST_H_SOFT: coef_base = FIELD_SOFT_IRON_MATRIX;
      ST_H_TARE: coef_base = FIELD_TARE_MATRIX;
      default: coef_base = ACCEL_OFFSET_VECTOR;
    endcase
  end
  wire logic [7:0] coef_addr = coef_base + 8'(row_q * ROW_BYTES) * {7'h0, ~is_sub}
                               + 8'(is_sub ? row_q : col_q) * COEF_BYTES;
  // Re-read every step so a byte update is never shadowed by a copy
  wire logic [31:0] coef = {cfg_q[coef_addr], cfg_q[coef_addr + 8'd1],
                            cfg_q[coef_addr + 8'd2], cfg_q[coef_addr + 8'd3]};

  wire logic [31:0] sub_in = (state_q == ST_H_SUB) ? in_h_q[row_q] : in_a_q[row_q];
  wire logic [31:0] sub_res = fp_add(sub_in, {~coef[FP_W-1], coef[30:0]});
  wire logic [31:0] vec_op = (state_q == ST_H_TARE) ? soft_q[col_q] : diff_q[col_q];
  wire logic [31:0] acc_base = (col_q == 2'd0) ? FP_ZERO : acc_q;
  // Identity and zero coefficients give exact pass-through
  wire logic [31:0] mac_res = fp_add(acc_base, fp_mul(coef, vec_op));
  wire logic last_row = (row_q == 2'd2);
  wire logic last_col = (col_q == 2'd2);

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start) state_d = ST_A_SUB;
      ST_A_SUB: if (last_row) state_d = ST_A_MUL;
      ST_A_MUL: if (last_row && last_col) state_d = ST_H_SUB;
      ST_H_SUB: if (last_row) state_d = ST_H_SOFT;
      ST_H_SOFT: if (last_row && last_col) state_d = ST_H_TARE;
      ST_H_TARE: if (last_row && last_col) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  wire logic phase_end = (state_d != state_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      row_q <= 2'd0;
      col_q <= 2'd0;
      acc_q <= FP_ZERO;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_q <= mac_res;
      if (phase_end || state_q == ST_IDLE) begin
        row_q <= 2'd0;
        col_q <= 2'd0;
      end else if (is_sub || last_col) begin
        row_q <= row_q + 2'd1;
        col_q <= 2'd0;
      end else begin
        col_q <= col_q + 2'd1;
      end
      if (state_q == ST_H_TARE && state_d == ST_IDLE) done_q <= 1'b1;
      else if (start) done_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        diff_q[i] <= FP_ZERO;
        soft_q[i] <= FP_ZERO;
        out_a_q[i] <= FP_ZERO;
        out_h_q[i] <= FP_ZERO;
      end
    end else begin
      if (is_sub) diff_q[row_q] <= sub_res;
      if (last_col && !is_sub) begin
        if (state_q == ST_A_MUL) out_a_q[row_q] <= mac_res;
        if (state_q == ST_H_SOFT) soft_q[row_q] <= mac_res;
        if (state_q == ST_H_TARE) out_h_q[row_q] <= mac_res;
      end
    end
  end

  // ==========================================================================
  // Register writes and configuration store
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_q <= 8'h00;
      for (int i = 0; i < 3; i++) begin
        in_a_q[i] <= FP_ZERO;
        in_h_q[i] <= FP_ZERO;
      end
    end else begin
      if (wr_en && reg_ofs == REG_MEM_ADDR && pstrb[0]) mem_addr_q <= pwdata[7:0];
      if (wr_en && sel_in_a && full_word) in_a_q[vec_idx] <= pwdata;
      if (wr_en && sel_in_h && full_word) in_h_q[vec_idx] <= pwdata;
    end
  end

  // Reset stands in for the non-volatile factory image
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CFG_USED_BYTES; i++) cfg_q[i] <= default_byte(i);
    end else begin
      if (mem_wr) cfg_q[mem_addr_q] <= pwdata[7:0];
      if (log_mode_we) begin
        cfg_q[SAMPLE_RATE_OFS] <= log_sample_rate;
        cfg_q[DECIMATION_RATIO_OFS] <= log_decimation_ratio;
      end
    end
  end

  assign sample_rate_byte = cfg_q[SAMPLE_RATE_OFS];
  assign decimation_ratio_byte = cfg_q[DECIMATION_RATIO_OFS];
  assign accel_converter_setup = cfg_q[ACCEL_CONVERTER_OFS];
  assign field_converter_setup = cfg_q[FIELD_CONVERTER_OFS];

endmodule : orient_comp

`default_nettype wire

// ===== verification/orient_comp_chk.sv
// Concurrent checks on the compensation block's bus and configuration ports.
// Assumes one clock (pclk) and asynchronous active-low presetn.
`timescale 1ns/10ps
`default_nettype none
module orient_comp_chk
  import orient_comp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic log_mode_we,
  input wire logic [7:0] log_sample_rate,
  input wire logic [7:0] log_decimation_ratio,
  input wire logic [7:0] sample_rate_byte,
  input wire logic [7:0] decimation_ratio_byte,
  input wire logic [7:0] accel_converter_setup
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic wr_done = acc && pwrite && pready;
  wire logic bad = (32'(paddr) > 32'(REG_LAST)) || (paddr[1:0] != 2'b00);
  sequence s_stall;
    acc && pwrite && !pready;
  endsequence
  sequence s_release;
    ##[1:40] (acc && pready);
  endsequence
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_stall_bounded: assert property (s_stall |-> s_release)
    else $error("write stall not released in time");
  a_read_no_wait: assert property (acc && !pwrite |-> pready)
    else $error("read access waited");
  a_unmapped_err: assert property (acc && pready && bad |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access flagged error");
  a_rdata_quiet: assert property ((!(acc && !pwrite) || bad) |-> prdata == 32'h0)
    else $error("read data not zero");
  a_log_rate: assert property (log_mode_we |=> sample_rate_byte == $past(log_sample_rate))
    else $error("sample rate not loaded by log pulse");
  a_log_decim: assert property (log_mode_we |=> decimation_ratio_byte == $past(log_decimation_ratio))
    else $error("decimation not loaded by log pulse");
  a_rate_hold: assert property ($changed(sample_rate_byte) |-> $past(log_mode_we || wr_done))
    else $error("sample rate changed without a write");
  a_conv_hold: assert property ($changed(accel_converter_setup) |-> $past(wr_done))
    else $error("converter byte changed without a write");
  a_reset_image: assert property ($rose(presetn) |->
    sample_rate_byte == SAMPLE_RATE_RST && decimation_ratio_byte == DECIMATION_RATIO_RST
    && accel_converter_setup == ACCEL_CONVERTER_RST)
    else $error("configuration bytes not at factory image");
endmodule : orient_comp_chk
bind orient_comp orient_comp_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .log_mode_we(log_mode_we),
  .log_sample_rate(log_sample_rate), .log_decimation_ratio(log_decimation_ratio),
  .sample_rate_byte(sample_rate_byte), .decimation_ratio_byte(decimation_ratio_byte),
  .accel_converter_setup(accel_converter_setup));
`default_nettype wire

// ===== verification/host_model.sv
// Host side: APB master issuing configuration byte commands and register
// accesses. Tasks are called from the testbench; one clock, pclk.
`timescale 1ns/10ps
`default_nettype none
module host_model
  import orient_comp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // ==========================================================================
  // Bus tasks
  // ==========================================================================
  // Idle cycle first, so no signal is assigned twice in one time step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ADDR_W'(a);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] b);
    logic [31:0] rd;
    if (a == ACCEL_CONVERTER_OFS || a == FIELD_CONVERTER_OFS) return;
    xfer(1'b1, REG_MEM_ADDR, {24'h0, a}, rd);
    xfer(1'b1, REG_MEM_DATA, {24'h0, b}, rd);
  endtask : wr_byte
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] b);
    logic [31:0] rd;
    xfer(1'b1, REG_MEM_ADDR, {24'h0, a}, rd);
    xfer(1'b0, REG_MEM_DATA, 32'h0, rd);
    b = rd[7:0];
  endtask : rd_byte
  task automatic wr_float(input logic [7:0] a, input logic [31:0] f);
    for (int i = 0; i < 4; i++) wr_byte(a + 8'(i), f[31-8*i -: 8]);
  endtask : wr_float
  // Quarter turn about z: orthonormal, determinant 1, same for both tares
  task automatic load_tares(input logic [31:0] s);
    for (int m = 0; m < 2; m++) begin
      wr_float((m == 0 ? ACCEL_TARE_MATRIX : FIELD_TARE_MATRIX), 32'h0);
      wr_float((m == 0 ? ACCEL_TARE_MATRIX : FIELD_TARE_MATRIX) + 8'h04, s ^ 32'h8000_0000);
      wr_float((m == 0 ? ACCEL_TARE_MATRIX : FIELD_TARE_MATRIX) + 8'h0c, s);
      wr_float((m == 0 ? ACCEL_TARE_MATRIX : FIELD_TARE_MATRIX) + 8'h10, 32'h0);
    end
  endtask : load_tares
endmodule : host_model
`default_nettype wire

// ===== verification/tb_orient_comp.sv
// Self-checking bench for orient_comp with the host model as APB master.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`default_nettype none
module tb_orient_comp
  import orient_comp_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, log_mode_we;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] log_sample_rate, log_decimation_ratio, rate_out, decim_out, acs, fcs, b;
  logic [31:0] rd;
  int errors, comparisons, cycles;
  orient_comp #(.ADDR_W(12)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .log_mode_we(log_mode_we),
    .log_sample_rate(log_sample_rate), .log_decimation_ratio(log_decimation_ratio),
    .sample_rate_byte(rate_out), .decimation_ratio_byte(decim_out),
    .accel_converter_setup(acs),
    .field_converter_setup(fcs));
  host_model #(.ADDR_W(12)) u_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready));
  // ==========================================================================
  // Common tasks
  // ==========================================================================
  task automatic close_out;
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Vectors packed x,y,z from the top; the write after the busy read stalls
  task automatic measure(input logic [95:0] ain, input logic [95:0] hin,
                         input logic [95:0] aexp, input logic [95:0] hexp);
    int n;
    for (int i = 0; i < 3; i++) begin
      u_host.xfer(1'b1, REG_IN_ACCEL + 8'(4*i), ain[95-32*i -: 32], rd);
      u_host.xfer(1'b1, REG_IN_FIELD + 8'(4*i), hin[95-32*i -: 32], rd);
    end
    u_host.xfer(1'b1, REG_CTRL, 32'h1, rd);
    // Reads are never stalled, so busy is visible while the engine runs
    u_host.xfer(1'b0, REG_STATUS, 32'h0, rd);
    check("busy", rd, 32'h1);
    u_host.xfer(1'b1, REG_MEM_ADDR, 32'h0, rd);
    n = 0;
    do begin
      u_host.xfer(1'b0, REG_STATUS, 32'h0, rd);
      n++;
    end while (rd[STAT_DONE_BIT] !== 1'b1 && n < 60);
    check("done", 32'(rd[STAT_DONE_BIT]), 32'h1);
    for (int i = 0; i < 3; i++) begin
      u_host.xfer(1'b0, REG_OUT_ACCEL + 8'(4*i), 32'h0, rd);
      check("accel out", rd, aexp[95-32*i -: 32]);
      u_host.xfer(1'b0, REG_OUT_FIELD + 8'(4*i), 32'h0, rd);
      check("field out", rd, hexp[95-32*i -: 32]);
    end
  endtask : measure
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_factory;
    check("rate port", 32'(rate_out), 32'h00);
    check("conv ports", {16'h0, acs, fcs}, 32'h0320);
    u_host.rd_byte(ACCEL_TARE_MATRIX, b);
    check("accel tare xx", 32'(b), 32'h3f);
    u_host.rd_byte(FIELD_TARE_MATRIX + 8'h11, b);
    check("field tare yy", 32'(b), 32'h80);
    u_host.rd_byte(DECIMATION_RATIO_OFS, b);
    check("decim byte", 32'(b), 32'h01);
    measure({32'h40400000, 32'h3f800000, 32'h40000000},
            {32'hbf800000, 32'h40000000, 32'h40400000},
            {32'h40400000, 32'h3f800000, 32'h40000000},
            {32'hbf800000, 32'h40000000, 32'h40400000});
  endtask : t_factory
  // Offsets, non-orthonormal soft iron, rotated tares, then live update
  task automatic t_compensate;
    u_host.wr_float(ACCEL_OFFSET_VECTOR, 32'h3f800000);
    u_host.wr_float(FIELD_HARD_IRON_OFFSET + 8'h08, 32'h3f800000);
    u_host.wr_float(FIELD_SOFT_IRON_MATRIX, 32'h40000000);
    u_host.load_tares(32'h3f800000);
    measure({32'h40400000, 32'h3f800000, 32'h40000000},
            {32'h3f800000, 32'h40000000, 32'h40400000},
            {32'hbf800000, 32'h40000000, 32'h40000000},
            {32'hc0000000, 32'h40000000, 32'h40000000});
    u_host.wr_float(ACCEL_OFFSET_VECTOR, 32'h0);
    measure({32'h40400000, 32'h3f800000, 32'h40000000},
            {32'h3f800000, 32'h40000000, 32'h40400000},
            {32'hbf800000, 32'h40400000, 32'h40000000},
            {32'hc0000000, 32'h40000000, 32'h40000000});
  endtask : t_compensate
  task automatic t_bytes;
    u_host.wr_byte(SAMPLE_RATE_OFS, 8'h5a);
    u_host.rd_byte(SAMPLE_RATE_OFS, b);
    check("rate byte", {b, rate_out}, 32'h5a5a);
    @(posedge pclk);
    log_mode_we <= 1'b1;
    log_sample_rate <= 8'h11;
    log_decimation_ratio <= 8'h22;
    @(posedge pclk);
    log_mode_we <= 1'b0;
    @(posedge pclk);
    check("log bytes", {rate_out, decim_out}, 32'h1122);
    u_host.wr_byte(RESERVED_BASE, 8'ha5);
    u_host.rd_byte(RESERVED_BASE, b);
    check("reserved first", 32'(b), 32'h0);
    u_host.wr_byte(8'hff, 8'ha5);
    u_host.rd_byte(8'hff, b);
    check("reserved last", 32'(b), 32'h0);
    u_host.xfer(1'b0, REG_MEM_ADDR, 32'h0, rd);
    check("mem addr", rd, 32'h0000_00ff);
    u_host.xfer(1'b0, REG_IN_ACCEL, 32'h0, rd);
    check("accel in x", rd, 32'h4040_0000);
    u_host.xfer(1'b0, 8'h40, 32'h0, rd);
    check("unmapped", rd, 32'h0);
  endtask : t_bytes
  // ==========================================================================
  // Clock, reset, timeout, sequence
  // ==========================================================================
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    presetn = 1'b0;
    log_mode_we = 1'b0;
    log_sample_rate = 8'h0;
    log_decimation_ratio = 8'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_factory();
    t_compensate();
    t_bytes();
    close_out();
  end
endmodule : tb_orient_comp
`default_nettype wire
